// [design/flm_map.vh]
// Constants for the loop mode, lock and clock supervision block
`ifndef FLM_MAP_VH
`define FLM_MAP_VH
`define FLM_ADDR_CTRL 4'h0
`define FLM_ADDR_MULT 4'h1
`define FLM_ADDR_STAT 4'h2
`define FLM_ADDR_ERR 4'h3
`define FLM_ADDR_WIN 4'h4
`define FLM_ADDR_DIV 4'h5
`define FLM_ADDR_TRIM 4'h6
`define FLM_MODE_SELF 2'h0
`define FLM_MODE_EI 2'h1
`define FLM_MODE_BE 2'h2
`define FLM_MODE_EE 2'h3
`define FLM_ST_OFF 3'h4
`define FLM_CTRL_MON_DIS 2
`define FLM_CTRL_REF_KIND 3
`define FLM_CTRL_RANGE 4
`define FLM_CTRL_SYNC_LOSS_RESET_EN 5
`define FLM_CTRL_CLOCK_LOSS_RESET_EN 6
`define FLM_STAT_IRQ 0
`define FLM_STAT_LOCK 1
`define FLM_STAT_LOL 2
`define FLM_STAT_LOC 3
`define FLM_STAT_EXT_REF_VALID 4
`define FLM_STAT_OSCS 5
`define FLM_CMP_INT 8'h08
`define FLM_CMP_EXT_LO 8'h02
`define FLM_CMP_EXT_HI 8'h80
`define FLM_LOCK_SAMPLES 3'h4
`define FLM_AVG_CYCLES 2'h3
`define FLM_SETTLE_CYCLES 3'h4
`define FLM_MULT_RESET 8'h40
`define FLM_WIN_LOCK_RESET 8'h02
`define FLM_WIN_UNLOCK_RESET 8'h08
`define FLM_DIV_RESET 8'h01
`define FLM_OSC_LOSS_LIMIT 8'hFF
`endif

// [design/flm_core.v]
// Mode sequencing, lock detection and clock-loss supervision for the loop generator
`timescale 1ns/1ps
`include "flm_map.vh"
module flm_core (
   input wire sys_clk, // System clock, 125 MHz
   input wire rst, // Asynchronous reset, active high (MCU reset)
   input wire [3:0] addr, // Register address
   input wire [7:0] wdata, // Write data
   input wire wr_en, // Write strobe
   input wire rd_en, // Read strobe
   input wire osc_pulse, // One pulse per controlled oscillator period
   input wire ref_pulse, // One pulse per external reference period
   input wire int_ref_pulse, // One pulse per internal reference period
   input wire ref_fast_ok, // Reference meets its minimum frequency
   input wire ref_lost, // Reference below loss threshold
   input wire osc_ready, // Oscillator reports stable
   input wire stop_req, // MCU is in stop
   input wire debug_active_en, // Debug keeps clocks in stop
   input wire osc_in_stop_en, // Masks the quiet_stop lock clear; oscillator still turned off in stop
   input wire startup_active, // Crystal start-up after stop exit
   output reg [7:0] rdata, // Read data, one cycle after read strobe
   output reg osc_enable, // Controlled oscillator and internal reference on
   output reg out_from_ref, // Output sourced from the external reference
   output reg [8:0] out_divide, // Output divider applied to the source
   output reg [7:0] filter_value, // Loop filter value
   output reg gen_off, // Output clock stopped
   output reg sync_loss_reset, // Reset request from lock loss
   output reg clock_loss_reset // Reset request from clock loss
);
   localparam [2:0] ST_SELF = {1'b0, `FLM_MODE_SELF};
   localparam [2:0] ST_EI = {1'b0, `FLM_MODE_EI};
   localparam [2:0] ST_BE = {1'b0, `FLM_MODE_BE};
   localparam [2:0] ST_EE = {1'b0, `FLM_MODE_EE};
   localparam [2:0] ST_OFF = `FLM_ST_OFF;

   reg [7:0] ctrl_reg;
   reg [7:0] mult_reg;
   reg [7:0] win_reg;
   reg [7:0] div_reg;
   reg [7:0] trim_reg;
   reg [2:0] state_reg;
   reg [1:0] off_req_reg;
   reg off_valid_reg;
   reg lock_reg;
   reg lol_reg;
   reg loc_reg;
   reg first_lock_reg;
   reg status_read_reg;
   reg stop_wake_flag_reg;
   reg stopped_dbg_reg;
   reg [2:0] settle_reg;
   reg [7:0] cmp_cnt_reg;
   reg [7:0] osc_cnt_reg;
   reg [7:0] err_reg;
   reg [2:0] lock_cnt_reg;
   reg [1:0] avg_cnt_reg;
   reg [9:0] avg_sum_reg;
   reg [7:0] osc_idle_reg;
   reg osc_mon_arm_reg;

   wire [1:0] mode_request = ctrl_reg[1:0];
   wire [1:0] mode_state = state_reg[1:0];
   wire monitor_disable = ctrl_reg[`FLM_CTRL_MON_DIS];
   wire ref_kind_select = ctrl_reg[`FLM_CTRL_REF_KIND];
   wire engaged = (state_reg == ST_EI) || (state_reg == ST_EE);
   reg ext_ref_valid;
   reg ref_mon;
   reg osc_mon;
   always @* begin
      // Reference valid forcing matrix
      ext_ref_valid = 1'b0;
      ref_mon = 1'b0;
      if (mode_request[1] == 1'b0) begin
         ext_ref_valid = 1'b0;
      end else if (state_reg == ST_OFF) begin
         if (mode_request == `FLM_MODE_BE && ref_kind_select && startup_active) begin
            ref_mon = 1'b1;
            ext_ref_valid = ref_fast_ok;
         end
      end else if (mode_request == `FLM_MODE_BE && !ref_kind_select) begin
         ext_ref_valid = 1'b1;
      end else begin
         ref_mon = 1'b1;
         ext_ref_valid = ref_fast_ok;
      end
      if (monitor_disable) begin
         ref_mon = 1'b0;
      end
      // Oscillator not watched in off or bypassed
      osc_mon = !monitor_disable && state_reg != ST_OFF && state_reg != ST_BE &&
         osc_mon_arm_reg;
   end

   wire osc_lost = osc_mon && (osc_idle_reg == `FLM_OSC_LOSS_LIMIT);
   wire ref_loss = ref_mon && ref_lost;
   wire clk_loss = osc_lost || ref_loss;
   wire sel_int = (state_reg != ST_EE);
   wire cmp_tick_src = sel_int ? int_ref_pulse : ref_pulse;
   wire [7:0] cmp_len = sel_int ? `FLM_CMP_INT :
      (ctrl_reg[`FLM_CTRL_RANGE] ? `FLM_CMP_EXT_HI : `FLM_CMP_EXT_LO);
   // A source switch can leave the count past a shorter length, so end on reaching or passing it
   wire cmp_done = cmp_tick_src && (cmp_cnt_reg >= cmp_len - 8'h01);
   wire [7:0] err_now = mult_reg - osc_cnt_reg;
   wire [7:0] err_abs = err_now[7] ? (8'h00 - err_now) : err_now;
   wire in_lock_win = err_abs <= {4'h0, win_reg[3:0]};
   wire in_unlock_win = err_abs <= {4'h0, win_reg[7:4]};
   wire unexpected_unlock = cmp_done && engaged && lock_reg && !in_unlock_win;
   wire sync_loss_evt = unexpected_unlock || (engaged && clk_loss) || stop_wake_flag_reg;
   wire clear_ack = wr_en && addr == `FLM_ADDR_STAT && wdata[`FLM_STAT_IRQ] &&
      status_read_reg;
   wire setting_change = wr_en && ((addr == `FLM_ADDR_MULT && wdata != mult_reg) ||
      (addr == `FLM_ADDR_CTRL && wdata[1:0] != mode_request) ||
      (addr == `FLM_ADDR_TRIM && state_reg == ST_EI && wdata != trim_reg));
   wire quiet_stop = stop_req && !debug_active_en && !osc_in_stop_en;
   wire [9:0] avg_total = avg_sum_reg + {{2{err_now[7]}}, err_now};

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= 8'h00;
         mult_reg <= `FLM_MULT_RESET;
         win_reg <= (`FLM_WIN_UNLOCK_RESET << 4) | `FLM_WIN_LOCK_RESET;
         div_reg <= `FLM_DIV_RESET;
         trim_reg <= 8'h00;
         status_read_reg <= 1'b0;
         rdata <= 8'h00;
      end else begin
         rdata <= 8'h00;
         if (rd_en) begin
            if (addr == `FLM_ADDR_CTRL) begin
               rdata <= ctrl_reg;
            end else if (addr == `FLM_ADDR_MULT) begin
               rdata <= mult_reg;
            end else if (addr == `FLM_ADDR_STAT) begin
               rdata <= {mode_state, osc_ready, ext_ref_valid, loc_reg, lol_reg, lock_reg,
                  lol_reg | loc_reg};
               status_read_reg <= 1'b1;
            end else if (addr == `FLM_ADDR_ERR) begin
               rdata <= err_reg;
            end else if (addr == `FLM_ADDR_WIN) begin
               rdata <= win_reg;
            end else if (addr == `FLM_ADDR_DIV) begin
               rdata <= div_reg;
            end else if (addr == `FLM_ADDR_TRIM) begin
               rdata <= trim_reg;
            end
         end
         if (clear_ack) begin
            status_read_reg <= 1'b0;
         end
         if (wr_en) begin
            if (addr == `FLM_ADDR_CTRL) begin
               ctrl_reg <= wdata;
            end else if (addr == `FLM_ADDR_MULT) begin
               mult_reg <= wdata;
            end else if (addr == `FLM_ADDR_WIN) begin
               win_reg <= wdata;
            end else if (addr == `FLM_ADDR_DIV) begin
               div_reg <= wdata;
            end else if (addr == `FLM_ADDR_TRIM) begin
               trim_reg <= wdata;
            end
         end
         // Fallback rewrites the request to match the new mode
         if (state_reg == ST_EE && clk_loss) begin
            ctrl_reg[1:0] <= (ref_loss || !ext_ref_valid) ? `FLM_MODE_SELF : `FLM_MODE_BE;
         end else if (state_reg == ST_BE && ref_loss) begin
            ctrl_reg[1:0] <= `FLM_MODE_SELF;
         end
      end
   end

   // Mode sequencer
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_SELF;
         off_req_reg <= `FLM_MODE_SELF;
         off_valid_reg <= 1'b0;
         settle_reg <= 3'h0;
         first_lock_reg <= 1'b1;
         stop_wake_flag_reg <= 1'b0;
         stopped_dbg_reg <= 1'b0;
      end else begin
         stop_wake_flag_reg <= 1'b0;
         // Request must stand several cycles before state follows
         if (setting_change) begin
            settle_reg <= `FLM_SETTLE_CYCLES;
         end else if (settle_reg != 3'h0) begin
            settle_reg <= settle_reg - 3'h1;
         end
         case (state_reg)
            ST_OFF: begin
               if (!stop_req) begin
                  if (off_req_reg == `FLM_MODE_BE && off_valid_reg) begin
                     state_reg <= ST_BE;
                  end else begin
                     state_reg <= ST_SELF;
                  end
               end
            end
            default: begin
               if (stop_req && !debug_active_en) begin
                  state_reg <= ST_OFF;
                  off_req_reg <= mode_request;
                  off_valid_reg <= ext_ref_valid;
               end else if (state_reg == ST_EE && clk_loss) begin
                  state_reg <= (osc_lost && !ref_loss && ext_ref_valid) ? ST_BE : ST_SELF;
               end else if (state_reg == ST_BE && ref_loss) begin
                  state_reg <= ST_SELF;
               end else if (settle_reg == 3'h0) begin
                  if (mode_request == `FLM_MODE_SELF) begin
                     state_reg <= ST_SELF;
                  end else if (mode_request == `FLM_MODE_EI && osc_ready) begin
                     state_reg <= ST_EI;
                  end else if (mode_request == `FLM_MODE_BE && ext_ref_valid &&
                     state_reg == ST_SELF) begin
                     state_reg <= ST_BE;
                  end else if (mode_request == `FLM_MODE_EE && ext_ref_valid && osc_ready &&
                     state_reg != ST_EE) begin
                     state_reg <= ST_EE;
                     first_lock_reg <= 1'b1;
                  end
               end
            end
         endcase
         // Debug dropped while stopped: unexpected clock stop
         if (!stop_req) begin
            stopped_dbg_reg <= 1'b0;
         end else if (state_reg != ST_OFF && debug_active_en) begin
            stopped_dbg_reg <= 1'b1;
         end
         if (state_reg == ST_OFF && !stop_req && stopped_dbg_reg) begin
            stop_wake_flag_reg <= 1'b1;
         end
         if (lock_reg) begin
            first_lock_reg <= 1'b0;
         end
      end
   end

   // Lock detector and averaged loop filter
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmp_cnt_reg <= 8'h00;
         osc_cnt_reg <= 8'h00;
         err_reg <= 8'h00;
         lock_cnt_reg <= 3'h0;
         lock_reg <= 1'b0;
         avg_cnt_reg <= 2'h0;
         avg_sum_reg <= 10'h000;
         filter_value <= 8'h80;
         osc_idle_reg <= 8'h00;
         osc_mon_arm_reg <= 1'b0;
      end else begin
         osc_idle_reg <= (osc_pulse || !osc_mon) ? 8'h00 :
            (osc_idle_reg == `FLM_OSC_LOSS_LIMIT ? osc_idle_reg : osc_idle_reg + 8'h01);
         if (state_reg == ST_OFF || state_reg == ST_BE) begin
            osc_mon_arm_reg <= 1'b0;
         end else if (osc_ready) begin
            osc_mon_arm_reg <= 1'b1;
         end
         if (cmp_tick_src) begin
            cmp_cnt_reg <= cmp_done ? 8'h00 : cmp_cnt_reg + 8'h01;
         end
         if (cmp_done) begin
            osc_cnt_reg <= {7'h00, osc_pulse};
            err_reg <= err_now;
         end else if (osc_pulse) begin
            osc_cnt_reg <= osc_cnt_reg + 8'h01;
         end
         if (!engaged || quiet_stop || setting_change || clk_loss) begin
            lock_reg <= 1'b0;
            lock_cnt_reg <= 3'h0;
            avg_cnt_reg <= 2'h0;
            avg_sum_reg <= 10'h000;
         end else if (cmp_done) begin
            if (!lock_reg) begin
               // Unlocked substate: filter follows each comparison
               filter_value <= filter_value + err_now;
               if (in_lock_win) begin
                  lock_cnt_reg <= lock_cnt_reg + 3'h1;
                  if (lock_cnt_reg == `FLM_LOCK_SAMPLES - 3'h1) begin
                     lock_reg <= 1'b1;
                  end
               end else begin
                  lock_cnt_reg <= 3'h0;
               end
            end else if (!in_unlock_win) begin
               lock_reg <= 1'b0;
               lock_cnt_reg <= 3'h0;
            end else if (avg_cnt_reg == `FLM_AVG_CYCLES) begin
               filter_value <= filter_value + avg_total[9:2];
               avg_cnt_reg <= 2'h0;
               avg_sum_reg <= 10'h000;
            end else begin
               avg_cnt_reg <= avg_cnt_reg + 2'h1;
               avg_sum_reg <= avg_total;
            end
         end
      end
   end

   // Sticky flags; a new event wins over an acknowledge
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lol_reg <= 1'b0;
         loc_reg <= 1'b0;
         sync_loss_reset <= 1'b0;
         clock_loss_reset <= 1'b0;
      end else begin
         sync_loss_reset <= sync_loss_evt && ctrl_reg[`FLM_CTRL_SYNC_LOSS_RESET_EN];
         clock_loss_reset <= clk_loss && ctrl_reg[`FLM_CTRL_CLOCK_LOSS_RESET_EN];
         if (sync_loss_evt) begin
            lol_reg <= 1'b1;
         end else if (clear_ack && !ctrl_reg[`FLM_CTRL_SYNC_LOSS_RESET_EN]) begin
            lol_reg <= 1'b0;
         end
         if (clk_loss) begin
            loc_reg <= 1'b1;
         end else if (clear_ack && !ctrl_reg[`FLM_CTRL_CLOCK_LOSS_RESET_EN]) begin
            loc_reg <= 1'b0;
         end
      end
   end

   // Output path selection
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_enable <= 1'b1;
         out_from_ref <= 1'b0;
         out_divide <= {1'b0, `FLM_DIV_RESET};
         gen_off <= 1'b0;
      end else begin
         gen_off <= (state_reg == ST_OFF);
         osc_enable <= (state_reg != ST_BE) && (state_reg != ST_OFF);
         out_from_ref <= (state_reg == ST_BE);
         if (state_reg == ST_EE && first_lock_reg && !lock_reg) begin
            out_divide <= {div_reg, 1'b0};
         end else begin
            out_divide <= {1'b0, div_reg};
         end
      end
   end
endmodule

// [tb/flm_core_checker.sv]
// Assertion checker bound to the loop mode and clock supervision block
`timescale 1ns/1ps
`include "flm_map.vh"
module flm_core_checker (
   input wire sys_clk, // System clock
   input wire rst, // Asynchronous reset
   input wire [3:0] addr, // Register address
   input wire [7:0] wdata, // Write data
   input wire wr_en, // Write strobe
   input wire rd_en, // Read strobe
   input wire stop_req, // MCU stop
   input wire debug_active_en, // Debug keeps clocks
   input wire [7:0] rdata, // Read data
   input wire osc_enable, // Oscillator on
   input wire out_from_ref, // Output from reference
   input wire [8:0] out_divide, // Output divider
   input wire gen_off, // Output stopped
   input wire sync_loss_reset, // Lock loss reset request
   input wire clock_loss_reset // Clock loss reset request
);
   reg [7:0] div_reg;
   reg [7:0] ctrl_reg;
   reg [2:0] quiet_reg;
   // Shadows of the divider and control; quiet counts cycles since a divider write
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_reg <= `FLM_DIV_RESET;
         ctrl_reg <= 8'h00;
         quiet_reg <= 3'h0;
      end else begin
         if (wr_en && addr == `FLM_ADDR_DIV) div_reg <= wdata;
         if (wr_en && addr == `FLM_ADDR_CTRL) ctrl_reg <= wdata;
         if (wr_en && addr == `FLM_ADDR_DIV) quiet_reg <= 3'h0;
         else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_bypass_osc_off;
      out_from_ref && !gen_off |-> !osc_enable;
   endproperty
   a_bypass_osc_off: assert property (p_bypass_osc_off)
      else $error("oscillator left running while output comes from reference");
   property p_bypass_div;
      out_from_ref && quiet_reg == 3'h7 |-> out_divide == {1'b0, div_reg};
   endproperty
   a_bypass_div: assert property (p_bypass_div)
      else $error("reference output divider differs from programmed divider");
   property p_div_choice;
      quiet_reg == 3'h7 |-> out_divide == {1'b0, div_reg} || out_divide == {div_reg, 1'b0};
   endproperty
   a_div_choice: assert property (p_div_choice)
      else $error("output divider is neither the divider nor twice it");
   property p_irq_sum;
      $past(rd_en) && $past(addr) == `FLM_ADDR_STAT |->
         rdata[`FLM_STAT_IRQ] == (rdata[`FLM_STAT_LOL] | rdata[`FLM_STAT_LOC]);
   endproperty
   a_irq_sum: assert property (p_irq_sum)
      else $error("status interrupt bit does not match loss flags");
   property p_lol_reset_en;
      sync_loss_reset |-> $past(ctrl_reg[`FLM_CTRL_SYNC_LOSS_RESET_EN]);
   endproperty
   a_lol_reset_en: assert property (p_lol_reset_en)
      else $error("lock loss reset requested while disabled");
   property p_loc_reset_en;
      clock_loss_reset |-> $past(ctrl_reg[`FLM_CTRL_CLOCK_LOSS_RESET_EN]);
   endproperty
   a_loc_reset_en: assert property (p_loc_reset_en)
      else $error("clock loss reset requested while disabled");
   property p_off_entry;
      $rose(gen_off) |-> $past(stop_req, 2) && !$past(debug_active_en, 2);
   endproperty
   a_off_entry: assert property (p_off_entry)
      else $error("off state entered without a quiet stop");
   property p_rdata_idle;
      !$past(rd_en) |-> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read answer");
   property p_unmapped;
      $past(rd_en) && $past(addr) > `FLM_ADDR_TRIM |-> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address returned nonzero data");
endmodule
bind flm_core flm_core_checker i_chk (.sys_clk(sys_clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .stop_req(stop_req),
   .debug_active_en(debug_active_en), .rdata(rdata), .osc_enable(osc_enable),
   .out_from_ref(out_from_ref), .out_divide(out_divide), .gen_off(gen_off),
   .sync_loss_reset(sync_loss_reset), .clock_loss_reset(clock_loss_reset));

// [tb/flm_core_tb_top.sv]
// Self-checking bench for the loop mode and clock supervision block
`timescale 1ns/1ps
`include "flm_map.vh"
module flm_core_tb_top;
   reg sys_clk, rst, wr_en, rd_en, ref_fast_ok, ref_lost, osc_ready;
   reg stop_req, debug_active_en, osc_in_stop_en, startup_active;
   reg osc_pulse, ref_pulse, int_ref_pulse, seen_locr, seen_lolr;
   reg [3:0] addr;
   reg [7:0] wdata, st;
   wire [7:0] rdata, filter_value;
   wire [8:0] out_divide;
   wire osc_enable, out_from_ref, gen_off, sync_loss_reset, clock_loss_reset;
   integer miscompares, tests_run, osc_per, cyc;
   flm_core i_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .osc_pulse(osc_pulse), .ref_pulse(ref_pulse),
      .int_ref_pulse(int_ref_pulse), .ref_fast_ok(ref_fast_ok), .ref_lost(ref_lost),
      .osc_ready(osc_ready), .stop_req(stop_req), .debug_active_en(debug_active_en),
      .osc_in_stop_en(osc_in_stop_en), .startup_active(startup_active), .rdata(rdata),
      .osc_enable(osc_enable), .out_from_ref(out_from_ref), .out_divide(out_divide),
      .filter_value(filter_value), .gen_off(gen_off), .sync_loss_reset(sync_loss_reset),
      .clock_loss_reset(clock_loss_reset));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Reference every 16 cycles: a low-range comparison spans 32 cycles, 16 pulses at period 2
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      osc_pulse <= (osc_per != 0) && (cyc % (osc_per == 0 ? 1 : osc_per) == 0);
      ref_pulse <= (cyc % 16 == 0);
      int_ref_pulse <= (cyc % 4 == 0);
      if (clock_loss_reset === 1'b1) seen_locr <= 1'b1;
      if (sync_loss_reset === 1'b1) seen_lolr <= 1'b1;
   end
   task chk(input [8*12-1:0] nm, input [8:0] seen, input [8:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge sys_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 st = rdata;
   endtask
   task poll(input [7:0] m, input [7:0] v, input integer n);
      integer i;
      rd(`FLM_ADDR_STAT);
      for (i = 0; i < n && (st & m) !== v; i = i + 1) rd(`FLM_ADDR_STAT);
   endtask
   task idle(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task t_reset_state;
      chk("osc_en", osc_enable, 1);
      chk("divide", out_divide, 9'h001);
      chk("filter", filter_value, 9'h080);
      rd(`FLM_ADDR_STAT);
      chk("status", st & 8'hcf, 0);
      wr(4'h9, 8'hff);
      rd(4'h9);
      chk("unmapped", st, 0);
   endtask
   task t_bypass;
      wr(`FLM_ADDR_DIV, 8'h03);
      wr(`FLM_ADDR_CTRL, 8'h0a);
      rd(`FLM_ADDR_STAT);
      chk("mode_early", st[7:6], 0);
      poll(8'hc0, 8'h80, 20);
      chk("mode_be", st[7:6], 2);
      chk("from_ref", out_from_ref, 1);
      chk("osc_off", osc_enable, 0);
      @(posedge sys_clk);
      ref_lost <= 1'b1;
      ref_fast_ok <= 1'b0;
      poll(8'hc8, 8'h08, 40);
      chk("ref_loss", st & 8'hc8, 9'h008);
      @(posedge sys_clk);
      ref_lost <= 1'b0;
      ref_fast_ok <= 1'b1;
      rd(`FLM_ADDR_STAT);
      wr(`FLM_ADDR_STAT, 8'h01);
      rd(`FLM_ADDR_STAT);
      chk("loc_clear", st[3], 0);
   endtask
   task t_engaged;
      wr(`FLM_ADDR_MULT, 8'h10);
      wr(`FLM_ADDR_CTRL, 8'h0b);
      poll(8'hc0, 8'hc0, 20);
      chk("mode_ee", st[7:6], 3);
      chk("div_twice", out_divide, 9'h006);
      poll(8'h02, 8'h02, 400);
      chk("locked", st[1], 1);
      chk("div_locked", out_divide, 9'h003);
      rd(`FLM_ADDR_ERR);
      chk("err_small", ($signed(st) <= 2) && ($signed(st) >= -2), 1);
      wr(`FLM_ADDR_MULT, 8'h11);
      rd(`FLM_ADDR_STAT);
      chk("exp_unlock", st[2:1], 0);
      poll(8'h02, 8'h02, 400);
      osc_per = 8;
      poll(8'h04, 8'h04, 400);
      chk("lol_set", st[2:1], 2);
      chk("div_relock", out_divide, 9'h003);
      osc_per = 2;
      idle(80);
      rd(`FLM_ADDR_STAT);
      chk("lol_sticky", st[2], 1);
      wr(`FLM_ADDR_STAT, 8'h01);
      rd(`FLM_ADDR_STAT);
      chk("lol_clear", st[2], 0);
   endtask
   task t_osc_loss;
      wr(`FLM_ADDR_CTRL, 8'h6b);
      osc_per = 0;
      poll(8'hc0, 8'h80, 400);
      chk("osc_loss", st & 8'hc8, 9'h088);
      chk("from_ref2", out_from_ref, 1);
      chk("loc_reset", seen_locr, 1);
      chk("lol_reset", seen_lolr, 1);
      osc_per = 2;
      @(posedge sys_clk);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      rd(`FLM_ADDR_STAT);
      chk("mcu_reset", st & 8'hcf, 0);
   endtask
   task t_stop;
      @(posedge sys_clk);
      stop_req <= 1'b1;
      idle(4);
      chk("gen_off", gen_off, 1);
      rd(`FLM_ADDR_STAT);
      chk("quiet_stop", st[2:1], 0);
      stop_req <= 1'b0;
      idle(4);
      debug_active_en <= 1'b1;
      stop_req <= 1'b1;
      idle(4);
      debug_active_en <= 1'b0;
      idle(4);
      stop_req <= 1'b0;
      idle(4);
      rd(`FLM_ADDR_STAT);
      chk("wake_lol", st[2], 1);
   endtask
   initial begin
      {wr_en, rd_en, ref_lost, stop_req, debug_active_en, osc_in_stop_en} = 6'h00;
      {startup_active, osc_pulse, ref_pulse, int_ref_pulse, seen_locr, seen_lolr} = 6'h00;
      {ref_fast_ok, osc_ready, rst} = 3'h7;
      addr = 4'h0;
      wdata = 8'h00;
      miscompares = 0;
      tests_run = 0;
      osc_per = 2;
      cyc = 0;
      idle(8);
      rst <= 1'b0;
      t_reset_state;
      t_bypass;
      t_engaged;
      t_osc_loss;
      t_stop;
      final_report;
   end
   initial begin
      #(8 * 60000);
      miscompares = miscompares + 1;
      final_report;
   end
endmodule
